// ### pkg/sfbi_pkg.sv
// constants, opcodes and register map for the status flag bit instruction block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sfbi_pkg;

   // status register bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // apb register byte offsets
   localparam logic [7:0] OFS_FLAGS   = 8'h00;
   localparam logic [7:0] OFS_INSTR   = 8'h04;
   localparam logic [7:0] OFS_WREG    = 8'h08;
   localparam logic [7:0] OFS_COUNT   = 8'h0C;

   // instr register fields: op [4:0], index [7:5], reg select [12:8]
   localparam int INSTR_OP_LSB  = 0;
   localparam int INSTR_IDX_LSB = 5;
   localparam int INSTR_REG_LSB = 8;

   // reset values
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] WREG_RESET  = 8'h00;

   // instruction codes
   typedef enum logic [4:0] {
      OP_IDLE   = 5'h00,
      OP_BSTORE = 5'h01,
      OP_BLOAD  = 5'h02,
      OP_C_SET  = 5'h03,
      OP_C_CLR  = 5'h04,
      OP_N_SET  = 5'h05,
      OP_N_CLR  = 5'h06,
      OP_Z_SET  = 5'h07,
      OP_Z_CLR  = 5'h08,
      OP_ION    = 5'h09,
      OP_IOFF   = 5'h0A,
      OP_S_SET  = 5'h0B,
      OP_S_CLR  = 5'h0C,
      OP_V_SET  = 5'h0D,
      OP_V_CLR  = 5'h0E,
      OP_SETT   = 5'h0F,
      OP_CLRT   = 5'h10,
      OP_H_SET  = 5'h11,
      OP_H_CLR  = 5'h12,
      OP_XSET   = 5'h13,
      OP_XCLR   = 5'h14
   } sfbi_op_e;

endpackage

// ### hdl/sfbi_core.sv
// status flag and bit transfer instruction executor with apb register access
module sfbi_core
   import sfbi_pkg::*;
#(
   parameter int NREGS = 32
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // status flags
   output logic      [7:0]  processor_flags_register,
   output logic             interrupt_enable
);

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   logic [7:0]  flags, next_flags;
   logic [7:0]  wreg [NREGS];
   logic [7:0]  next_wreg [NREGS];
   logic [4:0]  wsel, next_wsel;
   logic [31:0] count, next_count;
   logic [31:0] next_prdata;
   logic        next_pslverr;

   logic        acc_wr;
   logic        acc_rd;
   logic        mapped;
   sfbi_op_e    op;
   logic [2:0]  idx;
   logic [4:0]  rsel;

   // access phase decode, answered in the first access cycle
   assign acc_wr = psel & penable & pwrite;
   assign acc_rd = psel & penable & ~pwrite;
   assign mapped = (paddr == OFS_FLAGS) | (paddr == OFS_INSTR) | (paddr == OFS_WREG) | (paddr == OFS_COUNT);
   assign op     = sfbi_op_e'(pwdata[INSTR_OP_LSB +: 5]);
   assign idx    = pwdata[INSTR_IDX_LSB +: 3];
   assign rsel   = pwdata[INSTR_REG_LSB +: 5];

   //---------------------------------------------------------------------------
   // instruction execution and register writes
   //---------------------------------------------------------------------------
   always_comb begin
      next_flags = flags;
      next_wreg  = wreg;
      next_wsel  = wsel;
      next_count = count;
      if (acc_wr && paddr == OFS_FLAGS) begin
         next_flags = pwdata[7:0];
      end
      if (acc_wr && paddr == OFS_WREG) begin
         next_wreg[wsel] = pwdata[7:0];
      end
      if (acc_wr && paddr == OFS_INSTR) begin
         // each instruction completes in this single cycle
         next_count = count + 32'h00000001;
         next_wsel  = rsel;
         case (op)
            OP_IDLE: next_flags = flags;
            OP_BSTORE: next_flags[FLAG_T] = wreg[rsel][idx];
            OP_BLOAD:  next_wreg[rsel][idx] = flags[FLAG_T];
            OP_C_SET:  next_flags[FLAG_C] = 1'b1;
            OP_C_CLR:  next_flags[FLAG_C] = 1'b0;
            OP_N_SET:  next_flags[FLAG_N] = 1'b1;
            OP_N_CLR:  next_flags[FLAG_N] = 1'b0;
            OP_Z_SET:  next_flags[FLAG_Z] = 1'b1;
            OP_Z_CLR:  next_flags[FLAG_Z] = 1'b0;
            OP_ION:  next_flags[FLAG_I] = 1'b1;
            OP_IOFF: next_flags[FLAG_I] = 1'b0;
            OP_S_SET:  next_flags[FLAG_S] = 1'b1;
            OP_S_CLR:  next_flags[FLAG_S] = 1'b0;
            OP_V_SET:  next_flags[FLAG_V] = 1'b1;
            OP_V_CLR:  next_flags[FLAG_V] = 1'b0;
            OP_H_SET:  next_flags[FLAG_H] = 1'b1;
            OP_H_CLR:  next_flags[FLAG_H] = 1'b0;
            OP_SETT: next_flags[FLAG_T] = 1'b1;
            OP_CLRT: next_flags[FLAG_T] = 1'b0;
            OP_XSET: next_flags[idx] = 1'b1;
            OP_XCLR: next_flags[idx] = 1'b0;
            default: next_flags = flags;
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // read mux and error answer
   //---------------------------------------------------------------------------
   always_comb begin
      next_prdata  = 32'h00000000;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_pslverr = ~mapped;
         if (!pwrite) begin
            case (paddr)
               OFS_FLAGS: next_prdata = {24'h000000, flags};
               OFS_WREG:  next_prdata = {24'h000000, wreg[wsel]};
               OFS_INSTR: next_prdata = {27'h0000000, wsel};
               OFS_COUNT: next_prdata = count;
               default:   next_prdata = 32'h00000000;
            endcase
         end
      end else if (psel && penable) begin
         next_prdata  = prdata;
         next_pslverr = pslverr;
      end
   end

   //---------------------------------------------------------------------------
   // registers
   //---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags   <= FLAGS_RESET;
         wsel    <= 5'h00;
         count   <= 32'h00000000;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
         processor_flags_register <= FLAGS_RESET;
         interrupt_enable         <= 1'b0;
      end else begin
         flags   <= next_flags;
         wsel    <= next_wsel;
         count   <= next_count;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
         pready  <= psel & ~penable;
         processor_flags_register <= next_flags;
         interrupt_enable         <= next_flags[FLAG_I];
      end
   end

   // working register file, one generate entry per register
   for (genvar g = 0; g < NREGS; g++) begin : g_wreg
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            wreg[g] <= WREG_RESET;
         end else begin
            wreg[g] <= next_wreg[g];
         end
      end
   end

   //---------------------------------------------------------------------------
   // checks
   //---------------------------------------------------------------------------
   wire instr_go = psel & penable & pwrite & pready & (paddr == OFS_INSTR);
   wire [4:0] op_w = pwdata[4:0];

   carry_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_C_SET |=> flags[FLAG_C] && flags[7:1] == $past(flags[7:1]))
      else $error("carry set failed");
   carry_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_C_CLR |=> !flags[FLAG_C] && flags[7:1] == $past(flags[7:1]))
      else $error("carry clear failed");
   neg_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_N_SET |=> flags[FLAG_N] && flags[7:3] == $past(flags[7:3]))
      else $error("negative set failed");
   neg_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_N_CLR |=> !flags[FLAG_N] && flags[1:0] == $past(flags[1:0]))
      else $error("negative clear failed");
   zero_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_Z_SET |=> flags[FLAG_Z] && flags[7:2] == $past(flags[7:2]))
      else $error("zero set failed");
   zero_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_Z_CLR |=> !flags[FLAG_Z] && flags[FLAG_C] == $past(flags[FLAG_C]))
      else $error("zero clear failed");
   int_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_ION |=> interrupt_enable && flags[FLAG_I])
      else $error("interrupt enable not set");
   int_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_IOFF |=> !interrupt_enable && flags[6:0] == $past(flags[6:0]))
      else $error("interrupt enable not cleared");
   signed_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_S_SET |=> flags[FLAG_S] && flags[7:5] == $past(flags[7:5]))
      else $error("signed set failed");
   signed_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_S_CLR |=> !flags[FLAG_S] && flags[3:0] == $past(flags[3:0]))
      else $error("signed clear failed");
   ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_V_SET |=> flags[FLAG_V] && flags[7:4] == $past(flags[7:4]))
      else $error("overflow set failed");
   ovf_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_V_CLR |=> !flags[FLAG_V] && flags[2:0] == $past(flags[2:0]))
      else $error("overflow clear failed");
   half_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_H_SET |=> flags[FLAG_H] && flags[4:0] == $past(flags[4:0]))
      else $error("half carry set failed");
   half_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_H_CLR |=> !flags[FLAG_H] && flags[7:6] == $past(flags[7:6]))
      else $error("half carry clear failed");
   tflag_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_CLRT |=> !flags[FLAG_T] && flags[5:0] == $past(flags[5:0]))
      else $error("transfer clear failed");
   idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_IDLE |=> $stable(flags))
      else $error("idle changed flags");
   bit_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_BSTORE |=> flags[FLAG_T] == $past(wreg[pwdata[12:8]][pwdata[7:5]]))
      else $error("bit store wrong");
   bit_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_BLOAD |=> $stable(flags))
      else $error("bit load touched flags");
   load_value_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_BLOAD |=> wreg[wsel][$past(pwdata[7:5])] == flags[FLAG_T])
      else $error("bit load wrong value");
   xset_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_XSET |=> flags[$past(pwdata[7:5])])
      else $error("indexed set failed");
   xclr_a: assert property (@(posedge pclk) disable iff (!presetn)
      instr_go && op_w == OP_XCLR |=> !flags[$past(pwdata[7:5])])
      else $error("indexed clear failed");

endmodule // sfbi_core

// ### testbench/sfbi_core_test.sv
// self-checking bench for the status flag bit instruction block
module sfbi_core_test
   import sfbi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   //---------------------------------------------
   // signals and model state
   //---------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, interrupt_enable, er;
   logic [7:0]  paddr, processor_flags_register, ef, ew;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  op, r;
   logic [2:0]  i;
   int          num_errors, n_compared, ncount;
   // flag touched by each single-flag opcode, starting at the carry set code
   localparam int FB [16] = '{FLAG_C, FLAG_C, FLAG_N, FLAG_N, FLAG_Z, FLAG_Z, FLAG_I, FLAG_I,
                              FLAG_S, FLAG_S, FLAG_V, FLAG_V, FLAG_T, FLAG_T, FLAG_H, FLAG_H};

   sfbi_core #(.NREGS(32)) sfbi_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .processor_flags_register(processor_flags_register), .interrupt_enable(interrupt_enable));

   // 40 mhz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   //---------------------------------------------
   // helpers
   //---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; an idle cycle in front keeps drives one per time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) num_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // expected flags after one instruction
   function automatic logic [7:0] model(input logic [7:0] f, input logic [4:0] o, input logic [2:0] x,
                                        input logic [7:0] w);
      if (o == OP_BSTORE) f[FLAG_T] = w[x];
      else if (o == OP_XSET || o == OP_XCLR) f[x] = (o == OP_XSET);
      else if (o >= 5'h03 && o <= 5'h12) f[FB[o - 5'h03]] = o[0];
      return f;
   endfunction

   // issue one instruction and advance the model
   task automatic ex(input logic [4:0] o, input logic [2:0] x, input logic [4:0] g);
      apb(1'b1, OFS_INSTR, {19'h0, g, x, o});
      ncount++;
      ef = model(ef, o, x, ew);
      if (o == OP_BLOAD) ew[x] = ef[FLAG_T];
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   //---------------------------------------------
   // main sequence and watchdog
   //---------------------------------------------
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      {num_errors, n_compared, ncount} = 0;
      ef = FLAGS_RESET;
      ew = WREG_RESET;
      void'($urandom(32'h2f898dde));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk("flags after reset", rd, {24'h0, FLAGS_RESET});
      // every opcode on all-clear, all-set and random flags
      for (int k = 0; k < 63; k++) begin
         op = 5'(k % 21);
         i = 3'($urandom);
         r = 5'($urandom);
         ex(OP_IDLE, i, r);
         ew = 8'($urandom);
         ef = (k < 21) ? 8'h00 : (k < 42) ? 8'hFF : 8'($urandom);
         apb(1'b1, OFS_WREG, {24'h0, ew});
         apb(1'b1, OFS_FLAGS, {24'h0, ef});
         ex(op, i, r);
         apb(1'b0, OFS_FLAGS, 32'h0);
         chk("flags register", rd, {24'h0, ef});
         chk("flags port", {24'h0, processor_flags_register}, {24'h0, ef});
         chk("interrupt enable", {31'h0, interrupt_enable}, {31'h0, ef[FLAG_I]});
         apb(1'b0, OFS_WREG, 32'h0);
         chk("working register", rd, {24'h0, ew});
         chk("no error", {31'h0, er}, 32'h0);
         apb(1'b0, OFS_INSTR, 32'h0);
         chk("register select", rd, {27'h0, r});
      end
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("instruction count", rd, ncount);
      // unmapped address is refused and leaves the flags alone
      apb(1'b1, 8'h10, 32'hFF);
      chk("write refused", {31'h0, er}, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk("read refused", {31'h0, er}, 32'h1);
      chk("refused data", rd, 32'h0);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk("flags kept", rd, {24'h0, ef});
      test_done();
   end

   initial begin
      #(25ns * 20000);
      num_errors++;
      test_done();
   end

endmodule // sfbi_core_test
